/* rtl/obl_regs.svh */
`ifndef OBL_REGS_SVH
`define OBL_REGS_SVH

// flash layout
`define OBL_NBYTES     5
`define OBL_PRI_BASE   16'h0080
`define OBL_ALT_BASE   16'h1080
`define OBL_LAST_IDX   3'h4

// register indices, byte address is four times the index; control and status given as byte addresses
`define OBL_IDX_CLK    10'h080
`define OBL_IDX_RSV1   10'h081
`define OBL_IDX_RSV2   10'h082
`define OBL_IDX_RSV3   10'h083
`define OBL_IDX_DBG    10'h084
`define OBL_CTRL_ADDR  12'h000
`define OBL_STAT_ADDR  12'h004

// field positions
`define OBL_LOCK_BIT   0
`define OBL_HSSEL_BIT  1
`define OBL_STOP_BIT   0
`define OBL_CFG_CLK    0
`define OBL_CFG_DBG    4

// reset values
`define OBL_CFG_RST    8'h00
`define OBL_CTRL_RST   1'h0
`endif

/* rtl/obl_pkg.sv */
`default_nettype none
`include "obl_regs.svh"
package obl_pkg;
  typedef logic [7:0] obl_byte_t;
  typedef logic [`OBL_NBYTES-1:0][7:0] obl_cfg_t;
  typedef enum {FT_REQ, FT_WAIT, FT_DONE} obl_fetch_e;
endpackage
`default_nettype wire

/* rtl/obl_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// latched configuration shared by loader and users
interface obl_cfg_if;
  obl_pkg::obl_cfg_t bytes;
  logic              done;
  logic              swapped;
  modport loader (output bytes, output done, output swapped);
  modport user   (input bytes, input done, input swapped);
endinterface
`default_nettype wire

/* rtl/obl_fetch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "obl_regs.svh"
module obl_fetch (
  input  wire logic        clk,    // system clock
  input  wire logic        rst,    // sync reset
  input  wire logic        swap,   // boot swap active
  input  wire logic [7:0]  rdata,  // flash byte
  input  wire logic        rvalid, // flash byte valid
  output logic      [15:0] addr,   // flash address
  output logic             rd,     // flash read request
  obl_cfg_if.loader        cfg     // latched bytes
);
  obl_pkg::obl_fetch_e state;
  obl_pkg::obl_cfg_t   store;
  logic [2:0]          idx;
  logic                boot_swapped;
  logic                load_done;
  wire  [15:0]         base;
  wire                 take;
  wire                 last;

  // base and handshake decode
  // alternate block when swap was caught at reset, else primary block
  assign base = boot_swapped ? `OBL_ALT_BASE : `OBL_PRI_BASE;
  assign take = (state == obl_pkg::FT_WAIT) && rvalid;
  assign last = (idx == `OBL_LAST_IDX);

  // swap level caught while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_swapped <= swap;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= obl_pkg::FT_REQ;
      idx   <= 3'h0;
      rd    <= 1'b0;
      addr  <= 16'h0000;
    end else begin
      case (state)
        obl_pkg::FT_REQ: begin
          rd    <= 1'b1;
          addr  <= base + {13'h0000, idx};
          state <= obl_pkg::FT_WAIT;
        end
        obl_pkg::FT_WAIT: begin
          if (rvalid) begin
            rd    <= 1'b0;
            idx   <= idx + 3'h1;
            state <= last ? obl_pkg::FT_DONE : obl_pkg::FT_REQ;
          end
        end
        obl_pkg::FT_DONE: begin
          rd <= 1'b0;
        end
        default: begin
          state <= obl_pkg::FT_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      store     <= '0;
      load_done <= 1'b0;
    end else begin
      if (take) begin
        store[idx] <= rdata;
      end
      load_done <= load_done | (take && last);
    end
  end

  assign cfg.bytes   = store;
  assign cfg.done    = load_done;
  assign cfg.swapped = boot_swapped;
endmodule
`default_nettype wire

/* rtl/obl_osc_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "obl_regs.svh"
module obl_osc_ctl (
  input  wire logic clk,      // system clock
  input  wire logic rst,      // sync reset
  input  wire logic stop_req, // software stop request
  input  wire logic low_pwr,  // halt or stop mode
  input  wire logic tmr_int,  // timer on internal osc
  obl_cfg_if.user   cfg,      // latched bytes
  output logic      hs_rc,    // high-speed osc is rc
  output logic      ring_run, // internal osc running
  output logic      wdt_en,   // watchdog clock enable
  output logic      tmr_en    // timer clock enable
);
  wire lock;
  wire next_ring;
  wire next_wdt;

  assign lock      = cfg.bytes[`OBL_CFG_CLK][`OBL_LOCK_BIT];
  assign next_ring = lock | ~stop_req;
  // watchdog gated in low power when unlocked
  assign next_wdt  = next_ring & ~(~lock & low_pwr);

  // clock controls, defaults until bytes are loaded
  always_ff @(posedge clk) begin
    if (rst || !cfg.done) begin
      hs_rc    <= 1'b0;
      ring_run <= 1'b1;
      wdt_en   <= 1'b0;
      tmr_en   <= 1'b0;
    end else begin
      hs_rc    <= cfg.bytes[`OBL_CFG_CLK][`OBL_HSSEL_BIT];
      ring_run <= next_ring;
      wdt_en   <= next_wdt;
      tmr_en   <= tmr_int & next_ring;
    end
  end
endmodule
`default_nettype wire

/* rtl/obl_top.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "obl_regs.svh"
module obl_top (
  input  wire logic        CLK,          // system clock
  input  wire logic        RST,          // sync reset, high
  input  wire logic        PSEL,         // apb select
  input  wire logic        PENABLE,      // apb enable
  input  wire logic        PWRITE,       // apb direction
  input  wire logic [11:0] PADDR,        // apb byte address
  input  wire logic [31:0] PWDATA,       // apb write data
  output logic      [31:0] PRDATA,       // apb read data
  output logic             PREADY,       // apb ready
  output logic             PSLVERR,      // apb error
  output logic      [15:0] FLASH_ADDR,   // flash address
  output logic             FLASH_RD,     // flash read request
  input  wire logic [7:0]  FLASH_RDATA,  // flash data
  input  wire logic        FLASH_VALID,  // flash data valid
  input  wire logic        BOOT_SWAP,    // boot swap active
  input  wire logic        HALT_MODE,    // cpu in halt
  input  wire logic        STOP_MODE,    // cpu in stop
  input  wire logic        TMR_INT_SRC,  // timer on internal osc
  output logic             CPU_RUN,      // cpu may start
  output logic             HS_OSC_RC,    // hs osc is rc type
  output logic             RING_OSC_RUN, // internal osc on
  output logic             WDT_CLK_EN,   // watchdog clock on
  output logic             TMR_CLK_EN,   // timer clock on
  output logic             DBG_FAULT     // debug byte not zero
);
  obl_cfg_if cfg_bus ();

  logic        ring_osc_stop_req;
  wire  [9:0]  word;
  wire  [2:0]  cfg_i;
  wire         cfg_hit;
  wire         sel_ctrl;
  wire         sel_stat;
  wire         mapped;
  wire         access;
  wire         finish;
  wire         bad;
  wire         wr_ctrl;
  wire         ring_osc_lock;
  wire  [7:0]  dbg_byte;
  wire  [31:0] next_rdata;
  wire  [31:0] stat_word;
  wire  [31:0] ctrl_word;
  wire  [31:0] cfg_word;

  // loader walks the flash block after reset
  obl_fetch obl_fetch_inst (
    .clk    (CLK),
    .rst    (RST),
    .swap   (BOOT_SWAP),
    .rdata  (FLASH_RDATA),
    .rvalid (FLASH_VALID),
    .addr   (FLASH_ADDR),
    .rd     (FLASH_RD),
    .cfg    (cfg_bus.loader)
  );

  // clock control from latched bytes
  obl_osc_ctl obl_osc_ctl_inst (
    .clk      (CLK),
    .rst      (RST),
    .stop_req (ring_osc_stop_req),
    .low_pwr  (HALT_MODE | STOP_MODE),
    .tmr_int  (TMR_INT_SRC),
    .cfg      (cfg_bus.user),
    .hs_rc    (HS_OSC_RC),
    .ring_run (RING_OSC_RUN),
    .wdt_en   (WDT_CLK_EN),
    .tmr_en   (TMR_CLK_EN)
  );

  // address decode
  assign word     = PADDR[11:2];
  assign cfg_hit  = (word >= `OBL_IDX_CLK) && (word <= `OBL_IDX_DBG)
                    && (PADDR[1:0] == 2'h0);
  assign cfg_i    = 3'(word - `OBL_IDX_CLK);
  assign sel_ctrl = (PADDR == `OBL_CTRL_ADDR);
  assign sel_stat = (PADDR == `OBL_STAT_ADDR);
  assign mapped   = cfg_hit | sel_ctrl | sel_stat;

  // bus phases: one wait state, then completion
  assign access   = PSEL & PENABLE & ~PREADY;
  assign finish   = PSEL & PENABLE & PREADY;
  // config and status words are read only
  assign bad      = ~mapped | (PWRITE & ~sel_ctrl);
  assign wr_ctrl  = finish & PWRITE & sel_ctrl & ~PSLVERR;

  // fields seen by software
  assign ring_osc_lock = cfg_bus.bytes[`OBL_CFG_CLK][`OBL_LOCK_BIT];
  assign dbg_byte      = cfg_bus.bytes[`OBL_CFG_DBG];
  assign ctrl_word     = {31'h00000000, ring_osc_stop_req};
  assign stat_word     = {27'h0000000, DBG_FAULT, cfg_bus.swapped,
                          RING_OSC_RUN, CPU_RUN, cfg_bus.done};
  assign cfg_word      = {24'h000000, cfg_bus.bytes[cfg_i]};

  // read data select
  assign next_rdata = PWRITE   ? 32'h00000000 :
                      cfg_hit  ? cfg_word     :
                      sel_ctrl ? ctrl_word    :
                      sel_stat ? stat_word    : 32'h00000000;

  // apb response, answer one cycle into access phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY <= access;
      if (access) begin
        PSLVERR <= bad;
        PRDATA  <= next_rdata;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // stop request ignored while oscillator is locked
  always_ff @(posedge CLK) begin
    if (RST) begin
      ring_osc_stop_req <= `OBL_CTRL_RST;
    end else if (wr_ctrl) begin
      ring_osc_stop_req <= PWDATA[`OBL_STOP_BIT] & ~ring_osc_lock;
    end
  end

  // cpu held until every byte is in
  always_ff @(posedge CLK) begin
    if (RST) begin
      CPU_RUN <= 1'b0;
    end else begin
      CPU_RUN <= cfg_bus.done;
    end
  end

  // nonzero debug byte flagged, debug never enabled
  always_ff @(posedge CLK) begin
    if (RST) begin
      DBG_FAULT <= 1'b0;
    end else begin
      DBG_FAULT <= cfg_bus.done & (dbg_byte != `OBL_CFG_RST);
    end
  end

  // checks on the loader, clock controls, cpu gate, debug flag and bus answers
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // first read one edge after reset release
  sequence rst_release;
    $fell(RST);
  endsequence

  // software stop write on an unlocked oscillator
  sequence stop_write;
    wr_ctrl && PWDATA[`OBL_STOP_BIT] && !ring_osc_lock;
  endsequence

  // one full bus access
  sequence bus_access;
    access ##1 finish;
  endsequence

  // one byte taken from flash
  sequence flash_take;
    FLASH_RD && FLASH_VALID;
  endsequence

  fetch_start_a: assert property (
    rst_release |=> FLASH_RD && !cfg_bus.done)
    else $error("fetch did not start after reset");

  fetch_end_a: assert property (
    (FLASH_RD && FLASH_VALID && FLASH_ADDR[2:0] == `OBL_LAST_IDX)
    |=> cfg_bus.done)
    else $error("loader missed the last byte");

  base_addr_a: assert property (
    FLASH_RD |-> FLASH_ADDR[15:3] ==
      (cfg_bus.swapped ? `OBL_ALT_BASE : `OBL_PRI_BASE) >> 3)
    else $error("fetch from wrong block");

  cpu_gate_a: assert property (
    !cfg_bus.done |=> !CPU_RUN)
    else $error("cpu ran before bytes loaded");

  cpu_start_a: assert property (
    $rose(cfg_bus.done) |=> CPU_RUN ##1 CPU_RUN)
    else $error("cpu not released after load");

  cfg_hold_a: assert property (
    cfg_bus.done |=> $stable(cfg_bus.bytes) && !FLASH_RD)
    else $error("latched bytes changed");

  hs_sel_a: assert property (
    CPU_RUN |->
      HS_OSC_RC == cfg_bus.bytes[`OBL_CFG_CLK][`OBL_HSSEL_BIT])
    else $error("wrong high speed osc type");

  // stop takes effect two edges later
  stop_ok_a: assert property (
    (stop_write and CPU_RUN) |-> ##2 !RING_OSC_RUN)
    else $error("unlocked stop did not stop osc");

  lock_keep_a: assert property (
    CPU_RUN && ring_osc_lock |=> RING_OSC_RUN && !ring_osc_stop_req)
    else $error("locked osc stopped");

  wdt_gate_a: assert property (
    CPU_RUN && !ring_osc_lock && (HALT_MODE || STOP_MODE)
    |=> !WDT_CLK_EN)
    else $error("watchdog clocked in low power");

  wdt_keep_a: assert property (
    CPU_RUN && ring_osc_lock |=> WDT_CLK_EN)
    else $error("locked watchdog clock lost");

  // timer keeps clock in low power
  tmr_keep_a: assert property (
    CPU_RUN && TMR_INT_SRC && (ring_osc_lock || !ring_osc_stop_req)
    |=> TMR_CLK_EN)
    else $error("timer clock lost");

  dbg_flag_a: assert property (
    cfg_bus.done && dbg_byte != `OBL_CFG_RST |=> DBG_FAULT)
    else $error("debug byte fault not flagged");

  // bus answer timing
  bus_ready_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("bus answer not one wait state");

  // error on unmapped access
  bus_err_a: assert property (
    bus_access |-> PSLVERR == $past(bad))
    else $error("bus error wrong");

  reset_idle_a: assert property (
    rst_release |-> !FLASH_RD && !CPU_RUN && !PREADY && !DBG_FAULT
      && RING_OSC_RUN && !WDT_CLK_EN && !TMR_CLK_EN && !HS_OSC_RC)
    else $error("outputs not idle after reset");

  // read drops once a byte is taken
  flash_drop_a: assert property (
    flash_take |=> !FLASH_RD)
    else $error("flash read held after byte taken");

  flash_hold_a: assert property (
    FLASH_RD && !FLASH_VALID |=> FLASH_RD && $stable(FLASH_ADDR))
    else $error("flash request dropped early");

  addr_step_a: assert property (
    flash_take ##0 FLASH_ADDR[2:0] != `OBL_LAST_IDX
    |=> !FLASH_RD ##1
      (FLASH_RD && FLASH_ADDR == $past(FLASH_ADDR, 2) + 16'h0001))
    else $error("flash address did not step");

  // unlocked stop write stores the request
  stop_set_a: assert property (
    stop_write |=> ring_osc_stop_req)
    else $error("stop request not stored");

  lock_write_a: assert property (
    wr_ctrl && ring_osc_lock |=> !ring_osc_stop_req)
    else $error("stop request stored while locked");

  stop_clear_a: assert property (
    wr_ctrl && !PWDATA[`OBL_STOP_BIT]
    |=> !ring_osc_stop_req ##1 RING_OSC_RUN)
    else $error("oscillator did not restart");

  // timer clock off when not on internal osc
  tmr_off_a: assert property (
    CPU_RUN && !TMR_INT_SRC |=> !TMR_CLK_EN)
    else $error("timer clocked from wrong source");

  // clock controls at defaults until load
  early_off_a: assert property (
    !cfg_bus.done |=> !WDT_CLK_EN && !TMR_CLK_EN && !HS_OSC_RC)
    else $error("clock controls active before load");

  // clean debug byte raises no fault
  dbg_clear_a: assert property (
    cfg_bus.done && dbg_byte == `OBL_CFG_RST |=> !DBG_FAULT)
    else $error("fault flagged on clean debug byte");
endmodule
`default_nettype wire

/* dv/obl_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// flash array model answering one byte per read request
module obl_flash_model (
  input  wire logic        clk,   // system clock
  input  wire logic [39:0] cfg,   // programmed bytes, index 0 low
  input  wire logic [1:0]  lat,   // answer delay in cycles
  input  wire logic [15:0] addr,  // byte address
  input  wire logic        rd,    // read request
  output logic      [7:0]  rdata, // byte out
  output logic             valid  // byte valid pulse
);
  logic [1:0] cnt;
  wire  [7:0] word = cfg[8*addr[2:0] +: 8];

  // idle outputs at time zero
  initial begin
    valid = 1'b0;
    rdata = 8'h00;
    cnt   = 2'h0;
  end

  // wait the delay, show one byte for a cycle, else scramble data
  always @(posedge clk) begin
    if (rd && !valid && cnt >= lat) begin
      valid <= 1'b1;
      rdata <= word;
      cnt   <= 2'h0;
    end else begin
      valid <= 1'b0;
      rdata <= ~rdata;
      if (rd && !valid) cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* dv/test_option_byte_loader.sv */
`timescale 1ns/1ps
`default_nettype none
`include "obl_regs.svh"
// loader bench: flash model, bus driver and result checks
module test_option_byte_loader;
  logic        clk = 1'b0;
  logic        rst, psel, penable, pwrite, swap, halt, stop, tmr, sw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, f_rd, f_valid;
  logic        cpu_run, hs_rc, ring, wdt, tmr_en, dbg;
  logic [15:0] f_addr, base;
  logic [7:0]  f_rdata;
  logic [39:0] cfg, old;
  logic [1:0]  lat = 2'h0;
  logic [33:0] note;
  logic [33:0] exp_q[$];
  integer      seed = 91;
  integer      num_errors = 0;
  integer      tests_run = 0;
  int          k = 0;

  always #5 clk = ~clk;

  obl_top obl_top_inst (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FLASH_ADDR(f_addr),
    .FLASH_RD(f_rd), .FLASH_RDATA(f_rdata), .FLASH_VALID(f_valid),
    .BOOT_SWAP(swap), .HALT_MODE(halt), .STOP_MODE(stop),
    .TMR_INT_SRC(tmr), .CPU_RUN(cpu_run), .HS_OSC_RC(hs_rc),
    .RING_OSC_RUN(ring), .WDT_CLK_EN(wdt), .TMR_CLK_EN(tmr_en),
    .DBG_FAULT(dbg)
  );

  obl_flash_model obl_flash_model_inst (
    .clk(clk), .cfg(cfg), .lat(lat), .addr(f_addr), .rd(f_rd),
    .rdata(f_rdata), .valid(f_valid)
  );

  task automatic stop_test;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bus transfer; note holds compare flag, error and data
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [32:0] ex);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    exp_q.push_back({!wr && !ex[32], ex});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      stop_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // random flash delay
  always @(posedge clk) lat <= 2'($random(seed));

  // compare each bus answer with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) chk(prdata, note[31:0]);
    end
  end

  // each taken byte comes from base plus its position
  always @(posedge clk) begin
    if (rst) begin
      k <= 0;
    end else if (f_rd && f_valid) begin
      chk({16'h0, f_addr}, {16'h0, base + 16'(k)});
      chk({31'h0, cpu_run}, 32'h0);
      k <= k + 1;
    end
  end

  // four passes over oscillator settings and boot swap
  initial begin
    int i;
    int j;
    int n;
    {psel, penable, pwrite, halt, stop, tmr, swap, sw} = '0;
    paddr  = '0;
    pwdata = '0;
    rst    = 1'b1;
    cfg    = '0;
    base   = `OBL_PRI_BASE;
    for (i = 0; i < 4; i++) begin
      sw  = i[0] ^ i[1];
      old = {(i == 3) ? 8'h01 : 8'h00, 24'h0, 8'(i)};
      @(posedge clk);
      {halt, stop, tmr} <= 3'h0;
      cfg  <= old;
      swap <= sw;
      rst  <= 1'b1;
      base = sw ? `OBL_ALT_BASE : `OBL_PRI_BASE;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      if (n >= 200) begin
        num_errors++;
        stop_test();
      end
      #1;
      chk({31'h0, hs_rc}, {31'h0, old[1]});
      chk({31'h0, dbg}, {31'h0, old[39:32] != 8'h00});
      chk({29'h0, ring, wdt, tmr_en}, 32'h6);
      @(posedge clk);
      tmr  <= 1'b1;
      halt <= !i[0];
      stop <= i[0];
      cfg  <= ~old;
      cyc(2);
      chk({30'h0, wdt, tmr_en}, {30'h0, old[0], 1'b1});
      apb(1'b1, 12'h200, 32'hff, {1'b1, 32'h0});
      apb(1'b0, 12'h300, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 12'h202, 32'h0, {1'b1, 32'h0});
      apb(1'b1, `OBL_STAT_ADDR, 32'h1f, {1'b1, 32'h0});
      for (j = 0; j < 5; j++)
        apb(1'b0, 12'h200 + 12'(4 * j), 32'h0,
            {1'b0, 24'h0, old[8*j +: 8]});
      apb(1'b0, `OBL_STAT_ADDR, 32'h0,
          {1'b0, 27'h0, old[39:32] != 8'h00, sw, 3'h7});
      apb(1'b1, `OBL_CTRL_ADDR, $random(seed) | 32'h1, 33'h0);
      cyc(2);
      chk({30'h0, ring, tmr_en}, {30'h0, old[0], old[0]});
      apb(1'b0, `OBL_CTRL_ADDR, 32'h0, {1'b0, 31'h0, !old[0]});
      apb(1'b0, `OBL_STAT_ADDR, 32'h0,
          {1'b0, 27'h0, old[39:32] != 8'h00, sw, old[0], 2'h3});
      apb(1'b1, `OBL_CTRL_ADDR, 32'h0, 33'h0);
    end
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
